// [logic/pdm_defines.svh]
// constants for the programmable delay monostable: register map, fields, resets, timing
// assumes a single 25 MHz clk_sys and a 32-bit axi4-lite slave port
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

`define PDM_ADDR_W          8
`define PDM_DATA_W          32
`define PDM_CNT_W           24
`define PDM_SEC_W           8

// register byte offsets
`define PDM_OFF_CTRL        8'h00
`define PDM_OFF_OSC_PERIOD  8'h04
`define PDM_OFF_STATUS      8'h08
`define PDM_OFF_COUNT       8'h0C

// control register fields
`define PDM_CTRL_SEL_LSB    0
`define PDM_CTRL_SEL_MSB    3
`define PDM_CTRL_RETRIG     4
`define PDM_CTRL_OSC_RUN    5
`define PDM_CTRL_MCLR       6
`define PDM_CTRL_INT_OSC    7
`define PDM_CTRL_RESET      8'h00

// status register fields
`define PDM_STAT_ACTIVE     0
`define PDM_STAT_OSC_ON     1

// axi responses
`define PDM_RESP_OKAY       2'b00
`define PDM_RESP_SLVERR     2'b10

// timing
`define PDM_CLK_PERIOD_NS   40
`define PDM_MIN_DELAY_NS    100
`define PDM_MIN_DELAY_CYC   ((`PDM_MIN_DELAY_NS + `PDM_CLK_PERIOD_NS - 1) / `PDM_CLK_PERIOD_NS)
`define PDM_OSC_RESET       16'h0019

`endif

// [logic/pdm_pkg.sv]
// types for the programmable delay monostable
// assumes pdm_defines.svh for all numeric constants
package pdm_pkg;
    // gray along idle -> active
    typedef enum logic [1:0] {
        PDM_IDLE   = 2'b00,
        PDM_ACTIVE = 2'b01
    } pdm_state_t;
endpackage

// [logic/pdm_sync.sv]
// three-flop pin synchroniser with agreement filter and edge pulses
// assumes an asynchronous pin input and the clk_sys domain
`timescale 1ns/10ps
`default_nettype none
module pdm_sync
    import pdm_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);
    logic meta_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic agree;

    // first flop read only by the second
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_r <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
        end else begin
            meta_r <= pin_in;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
        end
    end

    // a change counts once the second and third stages agree
    assign agree = (s2_r == s3_r);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lvl_r <= 1'b0;
        end else if (agree) begin
            lvl_r <= s3_r;
        end
    end

    assign rise = agree & s3_r & ~lvl_r;
    assign fall = agree & ~s3_r & lvl_r;
endmodule
`default_nettype wire

// [logic/pdm_stage8.sv]
// one 8-stage binary section of the delay divider
// assumes clear has priority over count enable
`timescale 1ns/10ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_stage8
    import pdm_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    input  wire logic                   clr,
    input  wire logic                   en,
    output logic [`PDM_SEC_W-1:0]       cnt_r,
    output logic                        full
);
    // section counter, clear wins
    always_ff @(posedge clk_sys) begin
        if (reset || clr) begin
            cnt_r <= '0;
        end else if (en) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    assign full = &cnt_r;
endmodule
`default_nettype wire

// [logic/pdm_top.sv]
// programmable delay monostable with axi4-lite control registers
// assumes pins trig_pos, trig_neg, count_clock_in are asynchronous to clk_sys
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_top
    import pdm_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire logic                      trig_pos,
    input  wire logic                      trig_neg,
    input  wire logic                      count_clock_in,
    output logic                           pulse_out,
    output logic                           pulse_out_n,
    input  wire logic [`PDM_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [`PDM_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [`PDM_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [`PDM_DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    logic [7:0]             ctrl_r;
    logic [15:0]            osc_period_r;
    logic [`PDM_ADDR_W-1:0] awaddr_r;
    logic [`PDM_DATA_W-1:0] wdata_r;
    logic [3:0]             wstrb_r;
    logic                   awready_r;
    logic                   wready_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   arready_r;
    logic                   rvalid_r;
    logic [1:0]             rresp_r;
    logic [`PDM_DATA_W-1:0] rdata_r;
    pdm_state_t             state_r;
    pdm_state_t             state_nxt;
    logic                   pulse_r;
    logic                   pulse_n_r;
    logic [15:0]            osc_cnt_r;

    // pin synchronisers
    logic pos_rise;
    logic neg_fall;
    logic clk_rise;

    pdm_sync u_sync_pos (.clk_sys(clk_sys), .reset(reset), .pin_in(trig_pos), .rise(pos_rise), .fall());
    pdm_sync u_sync_neg (.clk_sys(clk_sys), .reset(reset), .pin_in(trig_neg), .rise(), .fall(neg_fall));
    pdm_sync u_sync_clk (.clk_sys(clk_sys), .reset(reset), .pin_in(count_clock_in), .rise(clk_rise), .fall());

    // control fields
    logic [3:0] sel;
    logic       retrig;
    logic       osc_run;
    logic       mclr;
    logic       int_osc;
    assign sel     = ctrl_r[`PDM_CTRL_SEL_MSB:`PDM_CTRL_SEL_LSB];
    assign retrig  = ctrl_r[`PDM_CTRL_RETRIG];
    assign osc_run = ctrl_r[`PDM_CTRL_OSC_RUN];
    assign mclr    = ctrl_r[`PDM_CTRL_MCLR];
    assign int_osc = ctrl_r[`PDM_CTRL_INT_OSC];

    // internal oscillator: a divider of clk_sys, gated off while idle in triggered-start mode
    logic        active;
    logic        osc_on;
    logic        osc_tick;
    logic [15:0] osc_limit;
    assign active = (state_r == PDM_ACTIVE);
    assign osc_on = int_osc & ~mclr & (osc_run | active);
    // period never under the minimum delay
    assign osc_limit = (osc_period_r < 16'(`PDM_MIN_DELAY_CYC)) ? 16'(`PDM_MIN_DELAY_CYC) : osc_period_r;
    assign osc_tick = osc_on & (osc_cnt_r == osc_limit - 16'h0001);

    // restarting from zero keeps the first period whole after a triggered start
    always_ff @(posedge clk_sys) begin
        if (reset || !osc_on || osc_tick) begin
            osc_cnt_r <= 16'h0000;
        end else begin
            osc_cnt_r <= osc_cnt_r + 16'h0001;
        end
    end

    // counting tick from the selected source
    logic tick;
    assign tick = int_osc ? osc_tick : clk_rise;

    // trigger and sequence events
    logic trig_evt;
    logic start_evt;
    logic retrig_evt;
    logic end_evt;
    logic done;
    logic [4:0] ratio_log;
    logic [`PDM_CNT_W-1:0] mask;
    logic [`PDM_CNT_W-1:0] cnt;
    assign trig_evt   = pos_rise | neg_fall;
    assign start_evt  = ~active & trig_evt & ~mclr;
    // extend on retrigger; ignored when retrigger is off
    assign retrig_evt = active & retrig & trig_evt & ~mclr;
    assign ratio_log  = sel[3] ? 5'd17 + {2'b00, sel[2:0]} : 5'd1 + {2'b00, sel[2:0]};
    assign mask       = 24'hFF_FFFF >> (5'd24 - ratio_log);
    assign done       = &(cnt | ~mask);
    assign end_evt    = active & tick & done & ~retrig_evt & ~mclr;

    logic sec_clr;
    logic sec_en;
    logic full0;
    logic full1;
    logic full2;
    logic [2:0] sec_en_v;
    assign sec_clr = ~active | mclr | start_evt | retrig_evt | end_evt;
    assign sec_en  = active & tick;
    // top bit low clocks the three sections in parallel
    // cascade lets a filled divider roll over in one tick
    assign sec_en_v[0] = sec_en;
    assign sec_en_v[1] = sec_en & (sel[3] ? full0 : 1'b1);
    assign sec_en_v[2] = sec_en & (sel[3] ? (full0 & full1) : 1'b1);

    pdm_stage8 u_sec0 (.clk_sys(clk_sys), .reset(reset), .clr(sec_clr), .en(sec_en_v[0]),
                       .cnt_r(cnt[7:0]), .full(full0));
    pdm_stage8 u_sec1 (.clk_sys(clk_sys), .reset(reset), .clr(sec_clr), .en(sec_en_v[1]),
                       .cnt_r(cnt[15:8]), .full(full1));
    pdm_stage8 u_sec2 (.clk_sys(clk_sys), .reset(reset), .clr(sec_clr), .en(sec_en_v[2]),
                       .cnt_r(cnt[23:16]), .full(full2));

    // clear overrides everything; start makes the output rise
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PDM_IDLE: begin
                if (start_evt) begin
                    state_nxt = PDM_ACTIVE;
                end
            end
            PDM_ACTIVE: begin
                if (mclr || end_evt) begin
                    state_nxt = PDM_IDLE;
                end
            end
            default: state_nxt = PDM_IDLE;
        endcase
    end

    // reset leaves both outputs idle; complementary outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r   <= PDM_IDLE;
            pulse_r   <= 1'b0;
            pulse_n_r <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            pulse_r   <= (state_nxt == PDM_ACTIVE);
            pulse_n_r <= (state_nxt != PDM_ACTIVE);
        end
    end

    assign pulse_out   = pulse_r;
    assign pulse_out_n = pulse_n_r;

    // axi write decode
    logic wr_go;
    logic wr_ctrl;
    logic wr_osc;
    logic wr_ok;
    assign wr_go   = ~awready_r & ~wready_r & ~bvalid_r;
    assign wr_ctrl = (awaddr_r == `PDM_OFF_CTRL);
    assign wr_osc  = (awaddr_r == `PDM_OFF_OSC_PERIOD);
    assign wr_ok   = wr_ctrl | wr_osc;

    // address and data taken in either order, response after both
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= `PDM_RESP_OKAY;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= 4'h0;
        end else begin
            if (awready_r && s_axi_awvalid) begin
                awready_r <= 1'b0;
                awaddr_r  <= s_axi_awaddr;
            end
            if (wready_r && s_axi_wvalid) begin
                wready_r <= 1'b0;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_ok ? `PDM_RESP_OKAY : `PDM_RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // software holds the select field in the control register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_r       <= `PDM_CTRL_RESET;
            osc_period_r <= `PDM_OSC_RESET;
        end else if (wr_go) begin
            if (wr_ctrl && wstrb_r[0]) begin
                ctrl_r <= wdata_r[7:0];
            end
            if (wr_osc && wstrb_r[0]) begin
                osc_period_r[7:0] <= wdata_r[7:0];
            end
            if (wr_osc && wstrb_r[1]) begin
                osc_period_r[15:8] <= wdata_r[15:8];
            end
        end
    end

    // read mux; unmapped reads answer slverr with zero data
    logic [`PDM_DATA_W-1:0] rd_data;
    logic                   rd_hit;
    assign rd_hit  = (s_axi_araddr == `PDM_OFF_CTRL) | (s_axi_araddr == `PDM_OFF_OSC_PERIOD) |
                     (s_axi_araddr == `PDM_OFF_STATUS) | (s_axi_araddr == `PDM_OFF_COUNT);
    assign rd_data = (s_axi_araddr == `PDM_OFF_CTRL)       ? {24'h00_0000, ctrl_r} :
                     (s_axi_araddr == `PDM_OFF_OSC_PERIOD) ? {16'h0000, osc_period_r} :
                     (s_axi_araddr == `PDM_OFF_STATUS)     ? {30'h0000_0000, osc_on, active} :
                     (s_axi_araddr == `PDM_OFF_COUNT)      ? {8'h00, cnt} : 32'h0000_0000;

    // single read outstanding, answer one cycle after the address
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= `PDM_RESP_OKAY;
            rdata_r   <= '0;
        end else if (arready_r && s_axi_arvalid) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= rd_hit ? `PDM_RESP_OKAY : `PDM_RESP_SLVERR;
            rdata_r   <= rd_data;
        end else if (rvalid_r && s_axi_rready) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    // checks on the timing sequence
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_mclr_idle;
        mclr |=> !pulse_out && pulse_out_n && (cnt == 24'h00_0000);
    endproperty
    a_mclr_idle: assert property (p_mclr_idle) else $error("master clear did not force idle");

    property p_compl;
        pulse_out_n == !pulse_out;
    endproperty
    a_compl: assert property (p_compl) else $error("outputs not complementary");

    property p_start;
        (!active && trig_evt && !mclr) |=> pulse_out ##0 (cnt == 24'h00_0000);
    endproperty
    a_start: assert property (p_start) else $error("trigger edge did not start pulse");

    property p_nonretrig;
        (active && !retrig && trig_evt && !tick && !mclr) |=> active && (cnt == $past(cnt));
    endproperty
    a_nonretrig: assert property (p_nonretrig) else $error("trigger disturbed non-retriggerable pulse");

    property p_retrig;
        (active && retrig && trig_evt && !mclr) |=> active && (cnt == 24'h00_0000);
    endproperty
    a_retrig: assert property (p_retrig) else $error("retrigger did not restart count");

    property p_end;
        (active && tick && done && !trig_evt && !mclr) |=> !pulse_out && pulse_out_n;
    endproperty
    a_end: assert property (p_end) else $error("pulse did not end after delay");

    property p_parallel;
        (active && tick && !sel[3] && !done && !trig_evt && !mclr) |=>
            (cnt[15:8] == $past(cnt[15:8]) + 8'h01) && (cnt[23:16] == $past(cnt[23:16]) + 8'h01);
    endproperty
    a_parallel: assert property (p_parallel) else $error("sections not clocked in parallel");

    property p_osc_gate;
        (!osc_run && !active) |-> !osc_tick;
    endproperty
    a_osc_gate: assert property (p_osc_gate) else $error("oscillator ran while idle in triggered mode");

    property p_ratio;
        (active && tick && !mclr && !trig_evt && (sel == 4'h0) && (cnt == 24'h00_0000)) |=> pulse_out;
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio two ended after one tick");

    c_start:   cover property (start_evt);
    c_retrig:  cover property (retrig_evt);
    c_end:     cover property (end_evt);
    c_testend: cover property (end_evt && sel == 4'hF && cnt == 24'hFF_FFFF);
endmodule
`default_nettype wire

// [test/pdm_far_end.sv]
// far-side model: trigger source and external counting clock
// assumes a free-running clk_sys; pins change just after its rising edge
`timescale 1ns/10ps
`default_nettype none
module pdm_far_end (
    input  wire logic clk_sys,
    output var logic  trig_pos,
    output var logic  trig_neg,
    output var logic  count_clock_in
);
    // idle levels: positive pin low, negative pin high, counting clock parked low
    initial begin
        trig_pos = 1'h0;
        trig_neg = 1'h1;
        count_clock_in = 1'h0;
    end

    // one edge on either pin
    // each level held four cycles so the synchroniser sees it settle
    task automatic trig(input logic neg);
        @(posedge clk_sys);
        if (neg) begin
            trig_neg <= 1'h0;
        end else begin
            trig_pos <= 1'h1;
        end
        repeat (4) @(posedge clk_sys);
        trig_neg <= 1'h1;
        trig_pos <= 1'h0;
        repeat (4) @(posedge clk_sys);
    endtask

    // counting clock rises, h cycles high and low; h under 2 would be too fast to sample
    task automatic ticks(input int n, input int h);
        repeat (n) begin
            count_clock_in <= 1'h1;
            repeat (h) @(posedge clk_sys);
            count_clock_in <= 1'h0;
            repeat (h) @(posedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the delay monostable and its register port
// assumes pdm_far_end drives the trigger and counting pins
`timescale 1ns/10ps
`default_nettype none
`include "pdm_defines.svh"
module testbench import pdm_pkg::*;;
    logic        clk_sys = 1'h0;
    logic        reset;
    wire logic   trig_pos, trig_neg, count_clock_in;
    logic        pulse_out, pulse_out_n;
    logic [7:0]  awaddr;
    logic [7:0]  araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    int          bad_count = 0, checked = 0, run_len = 0, last_len = 0;

    pdm_far_end far (.clk_sys(clk_sys), .trig_pos(trig_pos), .trig_neg(trig_neg),
        .count_clock_in(count_clock_in));
    pdm_top uut (.clk_sys(clk_sys), .reset(reset), .trig_pos(trig_pos), .trig_neg(trig_neg),
        .count_clock_in(count_clock_in), .pulse_out(pulse_out), .pulse_out_n(pulse_out_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    // length of the last high pulse, in clk_sys cycles
    always @(posedge clk_sys) begin
        if (pulse_out === 1'h1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            last_len <= run_len;
            run_len <= 0;
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_pins(input logic q);
        check_word({30'h0, pulse_out, pulse_out_n}, {30'h0, q, ~q});
    endtask

    // address and data offered together, each released when taken; released lines carry a changed pattern
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit aw_ok;
        bit w_ok;
        aw_ok = 0;
        w_ok = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys);
            if (!aw_ok && awready === 1'h1) begin
                aw_ok = 1;
                awvalid <= 1'h0;
                awaddr <= ~a;
            end
            if (!w_ok && wready === 1'h1) begin
                w_ok = 1;
                wvalid <= 1'h0;
                wdata <= ~d;
            end
        end
        while (bvalid !== 1'h1) begin
            @(posedge clk_sys);
        end
        check_word({30'h0, bresp}, {30'h0, er});
        bready <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk_sys);
        end while (arready !== 1'h1);
        arvalid <= 1'h0;
        araddr <= ~a;
        do begin
            @(posedge clk_sys);
        end while (rvalid !== 1'h1);
        check_word(rdata, ed);
        check_word({30'h0, rresp}, {30'h0, er});
        rready <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (pulse_out === 1'h1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (2) @(posedge clk_sys);
        check_pins(1'h0); // pulse ended
    endtask

    // reset values, refused places and byte lanes
    task automatic t_reset();
        check_pins(1'h0); // idle outputs
        rd(`PDM_OFF_CTRL, 32'h0000_0000, `PDM_RESP_OKAY); // control cleared
        rd(`PDM_OFF_OSC_PERIOD, {16'h0000, `PDM_OSC_RESET}, `PDM_RESP_OKAY);
        rd(`PDM_OFF_STATUS, 32'h0000_0000, `PDM_RESP_OKAY); // nothing running
        rd(8'h10, 32'h0000_0000, `PDM_RESP_SLVERR);
        wr(`PDM_OFF_STATUS, 32'h0000_0003, 4'hF, `PDM_RESP_SLVERR);
        wr(`PDM_OFF_CTRL, 32'h0000_0003, 4'h2, `PDM_RESP_OKAY);
        rd(`PDM_OFF_CTRL, 32'h0000_0000, `PDM_RESP_OKAY);
    endtask

    // every low select code, alternating the trigger pins and tick speed
    task automatic t_ratio();
        int r;
        for (int s = 0; s < 8; s++) begin
            r = 2 << s;
            wr(`PDM_OFF_CTRL, 32'(s), 4'hF, `PDM_RESP_OKAY); // select held
            far.trig(s[0]); // either pin starts
            check_pins(1'h1); // complementary pair
            far.ticks(r - 1, 3 + s % 2);
            check_pins(1'h1); // one tick short
            far.ticks(1, 3);
            check_pins(1'h0); // idle after ratio ticks
        end
    endtask

    // second trigger after three of four ticks
    task automatic t_retrig(input logic rt);
        wr(`PDM_OFF_CTRL, {27'h0, rt, 4'h1}, 4'hF, `PDM_RESP_OKAY);
        far.trig(1'h0);
        far.ticks(3, 3);
        far.trig(1'h1);
        far.ticks(1, 3);
        check_pins(rt); // extended or ignored
        if (rt) begin
            far.ticks(3, 3);
            check_pins(1'h0); // ends after full count
        end
    endtask

    task automatic t_clear();
        wr(`PDM_OFF_CTRL, 32'h0000_0001, 4'hF, `PDM_RESP_OKAY);
        far.trig(1'h0);
        check_pins(1'h1);
        wr(`PDM_OFF_CTRL, 32'h0000_0041, 4'hF, `PDM_RESP_OKAY);
        check_pins(1'h0); // pulse ended
        far.trig(1'h1);
        check_pins(1'h0); // trigger overridden
        rd(`PDM_OFF_COUNT, 32'h0000_0000, `PDM_RESP_OKAY); // stages cleared
        wr(`PDM_OFF_CTRL, 32'h0000_0001, 4'hF, `PDM_RESP_OKAY);
        far.trig(1'h0);
        check_pins(1'h1); // pulse running
        // a reset in mid-pulse must leave everything idle
        reset <= 1'h1;
        repeat (4) @(posedge clk_sys);
        reset <= 1'h0;
        @(posedge clk_sys);
        check_pins(1'h0); // reset ends pulse
        rd(`PDM_OFF_CTRL, 32'h0000_0000, `PDM_RESP_OKAY); // control cleared
    endtask

    task automatic t_test();
        wr(`PDM_OFF_CTRL, 32'h0000_0007, 4'hF, `PDM_RESP_OKAY); // test setting
        far.trig(1'h0);
        far.ticks(255, 3); // 255 clocks
        check_pins(1'h1); // still running
        rd(`PDM_OFF_COUNT, 32'h00FF_FFFF, `PDM_RESP_OKAY); // sections all high
        wr(`PDM_OFF_CTRL, 32'h0000_000F, 4'hF, `PDM_RESP_OKAY); // top bit raised
        far.ticks(1, 3);
        check_pins(1'h0); // output falls
        rd(`PDM_OFF_COUNT, 32'h0000_0000, `PDM_RESP_OKAY); // stages cleared
    endtask

    // internal oscillator, triggered start and continuous run
    task automatic t_osc();
        wr(`PDM_OFF_OSC_PERIOD, 32'h0000_000A, 4'hF, `PDM_RESP_OKAY);
        wr(`PDM_OFF_CTRL, 32'h0000_0081, 4'hF, `PDM_RESP_OKAY);
        rd(`PDM_OFF_STATUS, 32'h0000_0000, `PDM_RESP_OKAY); // oscillator stopped
        far.trig(1'h1);
        rd(`PDM_OFF_STATUS, 32'h0000_0003, `PDM_RESP_OKAY); // starts with pulse
        wait_idle();
        check_word(32'(last_len), 32'h0000_0028); // period 10 times ratio 4
        wr(`PDM_OFF_OSC_PERIOD, 32'h0000_0001, 4'hF, `PDM_RESP_OKAY);
        wr(`PDM_OFF_CTRL, 32'h0000_0080, 4'hF, `PDM_RESP_OKAY);
        far.trig(1'h0);
        wait_idle();
        check_word(32'(last_len), 32'(2 * `PDM_MIN_DELAY_CYC)); // shortest period times two
        wr(`PDM_OFF_CTRL, 32'h0000_00A0, 4'hF, `PDM_RESP_OKAY);
        rd(`PDM_OFF_STATUS, 32'h0000_0002, `PDM_RESP_OKAY); // runs continuously
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // main sequence after five cycles of reset
    initial begin
        reset <= 1'h1;
        awaddr <= 8'h00;
        araddr <= 8'h00;
        wdata <= 32'h0000_0000;
        wstrb <= 4'h0;
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        bready <= 1'h0;
        arvalid <= 1'h0;
        rready <= 1'h0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'h0;
        @(posedge clk_sys);
        t_reset();
        t_ratio();
        t_retrig(1'h0);
        t_retrig(1'h1);
        t_clear();
        t_test();
        t_osc();
        finish_test();
    end

    // watchdog, about three times the expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        finish_test();
    end
endmodule
`default_nettype wire
